// [hdl/secmode_pkg.sv]
// shared constants and types for the security mode controller and its host end
// assumes a single 200 MHz clock shared by both ends
package secmode_pkg;
    localparam int CLK_PERIOD_NS = 5;
    localparam int OPC_W = 8;
    localparam int RSP_W = 12;
    localparam int DAT_W = 8;
    // response codes
    localparam logic [11:0] RC_SUCCESS = 12'h000;
    localparam logic [11:0] RC_FAILURE = 12'h101;
    localparam logic [11:0] RC_BAD_MODE = 12'h100;
    localparam logic [11:0] RC_BAD_AUTH = 12'h102;
    localparam logic [11:0] RC_BAD_STRUCT = 12'h103;
    // command opcodes (chosen)
    localparam logic [7:0] CMD_FULL_SELF_TEST = 8'h01;
    localparam logic [7:0] CMD_CAPABILITY_QUERY = 8'h02;
    localparam logic [7:0] CMD_TEST_RESULT_QUERY = 8'h03;
    localparam logic [7:0] CMD_HASH = 8'h10;
    localparam logic [7:0] CMD_HMAC = 8'h11;
    localparam logic [7:0] CMD_SYM_CIPHER = 8'h12;
    localparam logic [7:0] CMD_DRBG = 8'h13;
    localparam logic [7:0] CMD_KDF = 8'h14;
    localparam logic [7:0] CMD_UNSEAL = 8'h20;
    localparam logic [7:0] CMD_ASYM_DECRYPT = 8'h21;
    localparam logic [7:0] CMD_KEY_GEN = 8'h30;
    localparam logic [7:0] CMD_KEY_ZEROIZE = 8'h31;
    localparam logic [7:0] CMD_SIGN = 8'h32;
    // self-test mask bits
    localparam int ST_W = 13;
    localparam logic [12:0] ST_LIMITED = 13'h07FF;
    localparam logic [12:0] ST_FULL = 13'h1FFF;
    // work time of one self-test item and one command, in cycles
    localparam int TEST_ITEM_CYCLES = 4;
    localparam int CMD_WORK_CYCLES = 4;
    typedef enum logic [1:0] {
        MODE_LIMITED,
        MODE_FULL,
        MODE_SHUTDOWN,
        MODE_FAILURE
    } sec_mode_t;
endpackage : secmode_pkg

// [hdl/secmode_if.sv]
// link between the host end and the security mode controller
// assumes both ends share clk; the testbench joins them
`timescale 1ns/1ps
`default_nettype none
interface secmode_if;
    import secmode_pkg::*;
    logic             cmdValid;
    logic             cmdReady;
    logic [7:0]       cmdOpcode;
    logic [7:0]       cmdParam;
    logic             cmdAuthOk;
    logic             cmdStructOk;
    logic             linkReset_n;
    logic             physicalPresence;
    logic             rspValid;
    logic [11:0]      rspCode;
    logic             dataValid;
    logic [7:0]       dataOut;
    logic             hostIrq;
    modport device (
        input  cmdValid, cmdOpcode, cmdParam, cmdAuthOk, cmdStructOk,
        input  linkReset_n, physicalPresence,
        output cmdReady, rspValid, rspCode, dataValid, dataOut, hostIrq
    );
    modport host (
        output cmdValid, cmdOpcode, cmdParam, cmdAuthOk, cmdStructOk,
        output linkReset_n, physicalPresence,
        input  cmdReady, rspValid, rspCode, dataValid, dataOut, hostIrq
    );
endinterface : secmode_if
`default_nettype wire

// [hdl/self_test_seq.sv]
// walks a set of self-test items and reports pass or the first failure
// assumes fault inputs are synchronous to clk
`timescale 1ns/1ps
`default_nettype none
module self_test_seq
    import secmode_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              reset_n,
    input  wire logic              start,
    input  wire logic [ST_W-1:0]   testMask,
    input  wire logic [ST_W-1:0]   faultIn,
    output logic                   busy,
    output logic                   done,
    output logic                   failed,
    output logic [ST_W-1:0]        failedMask
);
    logic [3:0] item;
    logic [2:0] tick;
    wire        itemFault = testMask[item] & faultIn[item];
    wire        lastItem  = (item == 4'(ST_W - 1));
    wire        tickEnd   = (tick == 3'(TEST_ITEM_CYCLES - 1));
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            busy <= 1'b0;
            done <= 1'b0;
            failed <= 1'b0;
            failedMask <= '0;
            item <= '0;
            tick <= '0;
        end else begin
            done <= 1'b0;
            if (start && !busy) begin
                busy <= 1'b1;
                failed <= 1'b0;
                failedMask <= '0;
                item <= '0;
                tick <= '0;
            end else if (busy) begin
                tick <= tickEnd ? 3'h0 : tick + 3'h1;
                if (tickEnd) begin
                    if (itemFault) begin
                        failed <= 1'b1;
                        failedMask[item] <= 1'b1;
                    end
                    if (lastItem || itemFault) begin
                        busy <= 1'b0;
                        done <= 1'b1;
                    end else begin
                        item <= item + 4'h1;
                    end
                end
            end
        end
    end
endmodule : self_test_seq
`default_nettype wire

// [hdl/security_mode_controller.sv]
// device end: operating mode tracking and command/response gating
// assumes host end on secmode_if, same clk; link pins already framed upstream
`timescale 1ns/1ps
`default_nettype none
module security_mode_controller
    import secmode_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              reset_n,
    input  wire logic              powerOn_n,
    input  wire logic              upgradeDone,
    input  wire logic              fwIntegrityFail,
    input  wire logic [ST_W-1:0]   testFault,
    secmode_if.device              link,
    output logic [1:0]             modeState,
    output logic                   selfTestPassedNv,
    output logic                   selfResetReq
);
    typedef enum logic [2:0] {
        S_BOOT,
        S_BOOT_TEST,
        S_IDLE,
        S_WORK,
        S_TEST,
        S_RESPOND
    } ctl_t;
    ctl_t      ctl;
    sec_mode_t mode;
    logic [1:0] rstSync;
    logic [2:0] work;
    logic [7:0] opc;
    logic [7:0] par;
    logic       authOk;
    logic       structOk;
    logic       stStart;
    logic [ST_W-1:0] lastResult;
    wire        stBusy;
    wire        stDone;
    wire        stFailed;
    wire [ST_W-1:0] stFailMask;
    // link reset comes from a pin
    // the pin counts as asserted until two edges have seen it high
    always_ff @(posedge clk) begin
        if (!reset_n) rstSync <= 2'h0;
        else rstSync <= {rstSync[0], link.linkReset_n};
    end
    wire linkRst = !rstSync[1];
    wire isQuery   = (opc == CMD_CAPABILITY_QUERY) || (opc == CMD_TEST_RESULT_QUERY);
    wire isLimited = (opc == CMD_HASH) || (opc == CMD_HMAC) || (opc == CMD_SYM_CIPHER) ||
                     (opc == CMD_DRBG) || (opc == CMD_KDF) || (opc == CMD_FULL_SELF_TEST) ||
                     isQuery;
    wire isKeyOp   = (opc == CMD_KEY_GEN) || (opc == CMD_KEY_ZEROIZE);
    wire isPlain   = (opc == CMD_UNSEAL) || (opc == CMD_ASYM_DECRYPT) || (opc == CMD_SYM_CIPHER);
    wire carriesData = !isKeyOp && (opc != CMD_FULL_SELF_TEST);
    wire allowed   = (mode == MODE_FULL) || ((mode == MODE_LIMITED) && isLimited) ||
                     ((mode == MODE_FAILURE) && isQuery);
    wire plainOk   = !isPlain || (structOk && authOk);
    wire [11:0] rspSel = (mode == MODE_FAILURE && !isQuery) ? RC_FAILURE :
                         !allowed ? RC_BAD_MODE :
                         !structOk ? RC_BAD_STRUCT :
                         !plainOk ? RC_BAD_AUTH : RC_SUCCESS;
    // queries in failure mode still answer with their data byte
    wire sendData = (rspSel == RC_SUCCESS) && carriesData && !stBusy &&
                    (mode != MODE_FAILURE || isQuery);
    wire [7:0] dataSel = (opc == CMD_TEST_RESULT_QUERY) ? lastResult[7:0] :
                         (opc == CMD_CAPABILITY_QUERY) ? {6'h00, mode} : par ^ opc;
    // a boot bound for full mode must already cover the asymmetric tests
    wire [ST_W-1:0] testSet = (mode == MODE_FULL || selfTestPassedNv ||
                               opc == CMD_FULL_SELF_TEST) ? ST_FULL : ST_LIMITED;
    self_test_seq u_test (
        .clk        (clk),
        .reset_n    (reset_n),
        .start      (stStart),
        .testMask   (testSet),
        .faultIn    (testFault),
        .busy       (stBusy),
        .done       (stDone),
        .failed     (stFailed),
        .failedMask (stFailMask)
    );
    // models the non-volatile flag: power-on leaves it as it is, upgrade clears it, a passed full self-test command sets it
    always_ff @(posedge clk) begin
        if (!powerOn_n) selfTestPassedNv <= selfTestPassedNv;
        if (upgradeDone) selfTestPassedNv <= 1'b0;
        else if (ctl == S_TEST && stDone && !stFailed && opc == CMD_FULL_SELF_TEST)
            selfTestPassedNv <= 1'b1;
    end
    // shutdown is held across reset; only power removal clears it
    always_ff @(posedge clk) begin
        if (!powerOn_n) selfResetReq <= 1'b0;
        else if (ctl == S_BOOT && fwIntegrityFail) selfResetReq <= 1'b1;
    end
    always_ff @(posedge clk) begin
        if (!reset_n || linkRst) begin
            ctl <= S_BOOT;
            mode <= selfResetReq ? MODE_SHUTDOWN : MODE_LIMITED;
            stStart <= 1'b0;
            work <= '0;
            opc <= '0;
            par <= '0;
            authOk <= 1'b0;
            structOk <= 1'b0;
            lastResult <= '0;
            link.cmdReady <= 1'b0;
            link.rspValid <= 1'b0;
            link.rspCode <= RC_SUCCESS;
            link.dataValid <= 1'b0;
            link.dataOut <= '0;
            link.hostIrq <= 1'b0;
        end else begin
            stStart <= 1'b0;
            link.rspValid <= 1'b0;
            link.dataValid <= 1'b0;
            link.dataOut <= '0;
            unique case (ctl)
                S_BOOT: begin
                    if (fwIntegrityFail || selfResetReq) begin
                        mode <= MODE_SHUTDOWN;
                    end else begin
                        stStart <= 1'b1;
                        ctl <= S_BOOT_TEST;
                    end
                end
                S_BOOT_TEST: begin
                    if (stDone) begin
                        lastResult <= stFailMask;
                        if (stFailed) mode <= MODE_FAILURE;
                        else mode <= selfTestPassedNv ? MODE_FULL : MODE_LIMITED;
                        ctl <= S_IDLE;
                        link.cmdReady <= 1'b1;
                    end
                end
                S_IDLE: begin
                    if (link.cmdValid && link.cmdReady) begin
                        opc <= link.cmdOpcode;
                        par <= link.cmdParam;
                        authOk <= link.cmdAuthOk;
                        structOk <= link.cmdStructOk;
                        link.cmdReady <= 1'b0;
                        link.hostIrq <= 1'b0;
                        work <= '0;
                        ctl <= S_WORK;
                    end
                end
                S_WORK: begin
                    work <= work + 3'h1;
                    if (work == 3'(CMD_WORK_CYCLES - 1)) begin
                        if (opc == CMD_FULL_SELF_TEST && allowed && structOk) begin
                            stStart <= 1'b1;
                            ctl <= S_TEST;
                        end else begin
                            ctl <= S_RESPOND;
                        end
                    end
                end
                S_TEST: begin
                    if (stDone) begin
                        lastResult <= stFailMask;
                        if (stFailed) mode <= MODE_FAILURE;
                        else if (mode == MODE_LIMITED) mode <= MODE_FULL;
                        ctl <= S_RESPOND;
                    end
                end
                S_RESPOND: begin
                    link.rspValid <= 1'b1;
                    link.rspCode <= rspSel;
                    link.dataValid <= sendData;
                    link.dataOut <= sendData ? dataSel : 8'h00;
                    link.hostIrq <= 1'b1;
                    link.cmdReady <= 1'b1;
                    ctl <= S_IDLE;
                end
                default: ctl <= S_BOOT;
            endcase
        end
    end
    // report shutdown even while the loop holds the core in reset
    always_ff @(posedge clk) begin
        if (!reset_n && selfResetReq) modeState <= 2'(MODE_SHUTDOWN);
        else if (!reset_n) modeState <= 2'(MODE_LIMITED);
        else modeState <= 2'(mode);
    end
endmodule : security_mode_controller
`default_nettype wire

// [hdl/host_controller.sv]
// host end: issues one command at a time and captures the answer
// assumes device end on secmode_if, same clk
`timescale 1ns/1ps
`default_nettype none
module host_controller
    import secmode_pkg::*;
(
    input  wire logic          clk,
    input  wire logic          reset_n,
    input  wire logic          reqValid,
    input  wire logic [7:0]    reqOpcode,
    input  wire logic [7:0]    reqParam,
    input  wire logic          reqAuthOk,
    input  wire logic          reqStructOk,
    input  wire logic          linkResetReq,
    input  wire logic          presence,
    secmode_if.host            link,
    output logic               reqReady,
    output logic               ansValid,
    output logic [11:0]        ansCode,
    output logic               ansDataValid,
    output logic [7:0]         ansData,
    output logic               irqSeen
);
    logic busy;
    wire  take = reqValid && reqReady;
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            busy <= 1'b0;
            reqReady <= 1'b0;
            link.cmdValid <= 1'b0;
            link.cmdOpcode <= '0;
            link.cmdParam <= '0;
            link.cmdAuthOk <= 1'b0;
            link.cmdStructOk <= 1'b0;
            link.linkReset_n <= 1'b0;
            link.physicalPresence <= 1'b0;
            ansValid <= 1'b0;
            ansCode <= RC_SUCCESS;
            ansDataValid <= 1'b0;
            ansData <= '0;
            irqSeen <= 1'b0;
        end else begin
            link.linkReset_n <= !linkResetReq;
            link.physicalPresence <= presence;
            ansValid <= 1'b0;
            ansDataValid <= 1'b0;
            irqSeen <= link.hostIrq;
            // no request is offered while the device end cannot take one
            reqReady <= !busy && !take && !link.cmdValid && link.cmdReady;
            if (take) begin
                busy <= 1'b1;
                link.cmdValid <= 1'b1;
                link.cmdOpcode <= reqOpcode;
                link.cmdParam <= reqParam;
                link.cmdAuthOk <= reqAuthOk;
                link.cmdStructOk <= reqStructOk;
            end else if (link.cmdValid && link.cmdReady) begin
                link.cmdValid <= 1'b0;
            end
            if (link.rspValid && busy) begin
                busy <= 1'b0;
                ansValid <= 1'b1;
                ansCode <= link.rspCode;
                ansDataValid <= link.dataValid;
                ansData <= link.dataOut;
            end
        end
    end
endmodule : host_controller
`default_nettype wire

// [sim/security_mode_controller_checker.sv]
// checker on the link between host end and device end
// assumes it sees the device's own reset, including shutdown loop requests
`timescale 1ns/1ps
`default_nettype none
module security_mode_controller_checker
    import secmode_pkg::*;
(
    input wire logic        clk,
    input wire logic        reset_n,
    input wire logic        cmdValid,
    input wire logic        cmdReady,
    input wire logic [7:0]  cmdOpcode,
    input wire logic        rspValid,
    input wire logic [11:0] rspCode,
    input wire logic        dataValid,
    input wire logic [7:0]  dataOut,
    input wire logic        hostIrq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    wire logic take   = cmdValid && cmdReady;
    wire logic keyCmd = (cmdOpcode == CMD_KEY_GEN) || (cmdOpcode == CMD_KEY_ZEROIZE);
    sequence s_taken;
        !cmdReady && !hostIrq;
    endsequence
    sequence s_answer;
        rspValid && cmdReady && hostIrq;
    endsequence
    // self-test runs longer, so every command but the full self-test is held to the exact walk
    property p_walk;
        take && cmdOpcode != CMD_FULL_SELF_TEST |=>
            s_taken ##1 (!rspValid && !cmdReady)[*4] ##1 s_answer;
    endproperty
    a_walk: assert property (p_walk) else $error("command walk timing wrong");
    property p_answer;
        take |-> ##[2:90] rspValid;
    endproperty
    a_answer: assert property (p_answer) else $error("no response after take");
    property p_data_ok;
        dataValid |-> rspValid && rspCode == RC_SUCCESS;
    endproperty
    a_data_ok: assert property (p_data_ok) else $error("data outside good response");
    property p_data_quiet;
        !dataValid |-> dataOut == 8'h00;
    endproperty
    a_data_quiet: assert property (p_data_quiet) else $error("data path not quiet");
    property p_fail_nodata;
        rspValid && rspCode == RC_FAILURE |-> !dataValid && cmdReady;
    endproperty
    a_fail_nodata: assert property (p_fail_nodata) else $error("failure code with data");
    property p_key_nodata;
        take && keyCmd |-> ##6 (rspValid && !dataValid);
    endproperty
    a_key_nodata: assert property (p_key_nodata) else $error("key command sent data");
    property p_rsp_pulse;
        rspValid |=> !rspValid;
    endproperty
    a_rsp_pulse: assert property (p_rsp_pulse) else $error("response longer than a cycle");
    property p_ready_hold;
        cmdReady && !cmdValid |=> cmdReady;
    endproperty
    a_ready_hold: assert property (p_ready_hold) else $error("ready dropped while idle");
    property p_irq_hold;
        hostIrq && !take |=> $stable(hostIrq);
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped early");
endmodule : security_mode_controller_checker
`default_nettype wire

// [sim/security_mode_controller_bench.sv]
// self-checking bench: host end and device end joined on one link
// assumes one 200 MHz clock; shutdown reset requests are fed back into reset
`timescale 1ns/1ps
`default_nettype none
module security_mode_controller_bench
    import secmode_pkg::*;
;
    localparam logic [7:0] OPS [13] = '{CMD_FULL_SELF_TEST, CMD_CAPABILITY_QUERY,
        CMD_TEST_RESULT_QUERY, CMD_HASH, CMD_HMAC, CMD_SYM_CIPHER, CMD_DRBG, CMD_KDF,
        CMD_UNSEAL, CMD_ASYM_DECRYPT, CMD_KEY_GEN, CMD_KEY_ZEROIZE, CMD_SIGN};
    logic        clk;
    logic        rstN;
    logic        powerOn_n;
    logic        upgradeDone;
    logic        fwIntegrityFail;
    logic [12:0] testFault;
    logic        reqValid;
    logic [7:0]  reqOpcode;
    logic [7:0]  reqParam;
    logic        reqAuthOk;
    logic        reqStructOk;
    logic        linkResetReq;
    logic        presence;
    logic        reqReady;
    logic        ansValid;
    logic [11:0] ansCode;
    logic        ansDataValid;
    logic [7:0]  ansData;
    logic        irqSeen;
    logic        nvFlag;
    logic [1:0]  modeState;
    logic        selfResetReq;
    logic [1:0]  mode;
    logic [12:0] fault;
    logic        nvDone;
    int          failures;
    int          comparisons;
    int          cycles = 0;
    // device reset also follows its own shutdown loop request
    wire logic   devReset_n = rstN && (selfResetReq !== 1'b1);
    secmode_if secmode_if_i ();
    security_mode_controller security_mode_controller_i (.clk(clk), .reset_n(devReset_n),
        .powerOn_n(powerOn_n), .upgradeDone(upgradeDone), .fwIntegrityFail(fwIntegrityFail),
        .testFault(testFault), .link(secmode_if_i), .modeState(modeState),
        .selfTestPassedNv(nvFlag), .selfResetReq(selfResetReq));
    host_controller host_controller_i (.clk(clk), .reset_n(rstN), .reqValid(reqValid),
        .reqOpcode(reqOpcode), .reqParam(reqParam), .reqAuthOk(reqAuthOk),
        .reqStructOk(reqStructOk), .linkResetReq(linkResetReq), .presence(presence),
        .link(secmode_if_i), .reqReady(reqReady), .ansValid(ansValid), .ansCode(ansCode),
        .ansDataValid(ansDataValid), .ansData(ansData), .irqSeen(irqSeen));
    security_mode_controller_checker security_mode_controller_checker_i (.clk(clk),
        .reset_n(devReset_n && secmode_if_i.linkReset_n), .cmdValid(secmode_if_i.cmdValid),
        .cmdReady(secmode_if_i.cmdReady), .cmdOpcode(secmode_if_i.cmdOpcode),
        .rspValid(secmode_if_i.rspValid), .rspCode(secmode_if_i.rspCode),
        .dataValid(secmode_if_i.dataValid), .dataOut(secmode_if_i.dataOut),
        .hostIrq(secmode_if_i.hostIrq));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic give_verdict;
        if (failures == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : give_verdict
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            failures++;
            give_verdict;
        end
    end
    task automatic tick;
        @(posedge clk);
        #1;
    endtask : tick
    task automatic chk_code(input logic [11:0] got, input logic [11:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t code %h expected %h", $time, got, exp);
        end
    endtask : chk_code
    task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t value %h expected %h", $time, got, exp);
        end
    endtask : chk_val
    function automatic logic [11:0] exp_code(input logic [7:0] o, input logic a, input logic s);
        logic q;
        q = (o == CMD_CAPABILITY_QUERY) || (o == CMD_TEST_RESULT_QUERY);
        if (mode == 2'h3 && !q) return RC_FAILURE;
        if (mode == 2'h0 && !(q || o == CMD_FULL_SELF_TEST || (o >= CMD_HASH && o <= CMD_KDF)))
            return RC_BAD_MODE;
        if (!s) return RC_BAD_STRUCT;
        if (!a && (o == CMD_UNSEAL || o == CMD_ASYM_DECRYPT || o == CMD_SYM_CIPHER))
            return RC_BAD_AUTH;
        return RC_SUCCESS;
    endfunction : exp_code
    // one command: hold the request until taken, then check the single answer
    task automatic cmd(input logic [7:0] o, input logic a, input logic s);
        int          n;
        logic [11:0] e;
        logic        d;
        e = exp_code(o, a, s);
        d = (e == RC_SUCCESS) && o != CMD_FULL_SELF_TEST && o != CMD_KEY_GEN
            && o != CMD_KEY_ZEROIZE;
        reqOpcode = o;
        reqParam = 8'($urandom);
        reqAuthOk = a;
        reqStructOk = s;
        reqValid = 1'b1;
        n = 0;
        while (reqReady !== 1'b1 && n < 400) begin
            tick;
            n++;
        end
        tick;
        reqValid = 1'b0;
        while (ansValid !== 1'b1 && n < 800) begin
            tick;
            n++;
        end
        if (n >= 800) failures++;
        chk_code(ansCode, e);
        chk_val({7'h00, ansDataValid}, {7'h00, d});
        chk_val({7'h00, irqSeen}, 8'h01);
        if (!d) chk_val(ansData, 8'h00);
        if (o == CMD_CAPABILITY_QUERY && d) chk_val(ansData, {6'h00, mode});
        if (o == CMD_TEST_RESULT_QUERY && mode == 2'h3 && d) chk_val(ansData, fault[7:0]);
        if (o == CMD_FULL_SELF_TEST && e == RC_SUCCESS) begin
            mode = 2'h1;
            nvDone = 1'b1;
        end
        tick;
    endtask : cmd
    // power cycle and reset together; the stored self-test flag survives unless upgraded
    task automatic boot(input logic up, input logic fw, input logic [12:0] f);
        int n;
        rstN = 1'b0;
        powerOn_n = 1'b0;
        upgradeDone = up;
        fwIntegrityFail = fw;
        testFault = f;
        fault = f;
        if (up) nvDone = 1'b0;
        tick;
        powerOn_n = 1'b1;
        upgradeDone = 1'b0;
        repeat (4) tick;
        rstN = 1'b1;
        mode = fw ? 2'h2 : (f != 0 ? 2'h3 : (nvDone ? 2'h1 : 2'h0));
        n = 0;
        while (reqReady !== 1'b1 && n < 300) begin
            tick;
            n++;
        end
        if (fw) begin
            chk_val({7'h00, selfResetReq}, 8'h01);
            chk_val({7'h00, reqReady}, 8'h00);
        end
        chk_val({6'h00, modeState}, {6'h00, mode});
        chk_val({7'h00, nvFlag}, {7'h00, nvDone});
    endtask : boot
    initial begin
        rstN = 1'b0;
        powerOn_n = 1'b0;
        upgradeDone = 1'b0;
        fwIntegrityFail = 1'b0;
        testFault = 13'h0000;
        reqValid = 1'b0;
        reqOpcode = 8'h00;
        reqParam = 8'h00;
        reqAuthOk = 1'b1;
        reqStructOk = 1'b1;
        linkResetReq = 1'b0;
        presence = 1'b0;
        mode = 2'h0;
        fault = 13'h0000;
        nvDone = 1'b0;
        failures = 0;
        comparisons = 0;
        void'($urandom(95222));
        boot(1'b1, 1'b0, 13'h0000);
        foreach (OPS[i]) if (OPS[i] != CMD_FULL_SELF_TEST) cmd(OPS[i], 1'b1, 1'b1);
        cmd(CMD_FULL_SELF_TEST, 1'b1, 1'b1);
        chk_val({6'h00, modeState}, 8'h01);
        cmd(CMD_SIGN, 1'b1, 1'b1);
        cmd(CMD_KEY_GEN, 1'b1, 1'b1);
        cmd(CMD_KEY_ZEROIZE, 1'b1, 1'b1);
        cmd(CMD_UNSEAL, 1'b0, 1'b1);
        cmd(CMD_ASYM_DECRYPT, 1'b1, 1'b0);
        cmd(CMD_SYM_CIPHER, 1'b1, 1'b1);
        repeat (20) cmd(OPS[$urandom % 13], 1'($urandom), 1'($urandom));
        boot(1'b0, 1'b0, 13'h0000);
        boot(1'b0, 1'b0, 13'h0001 << ($urandom % 13));
        repeat (12) cmd(OPS[$urandom % 13], 1'b1, 1'b1);
        cmd(CMD_TEST_RESULT_QUERY, 1'b1, 1'b1);
        // a link reset in mid-run reboots the device and clears failure mode
        testFault = 13'h0000;
        linkResetReq = 1'b1;
        repeat (8) tick;
        linkResetReq = 1'b0;
        mode = 2'h1;
        while (reqReady !== 1'b1) tick;
        chk_val({6'h00, modeState}, 8'h01);
        boot(1'b0, 1'b1, 13'h0000);
        boot(1'b0, 1'b0, 13'h0000);
        give_verdict;
    end
endmodule : security_mode_controller_bench
`default_nettype wire
